// ==== verilog/sgt_pkg.sv ====
// constants and strap encodings for the supply supervisor control logic
// assumes a single 25 MHz reference clock drives all timing
package sgt_pkg;

	// ----------------------------------------------------------------
	// clock and timing figures
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int PG_HOLD_NS = 6250000;
	localparam int WD_SHORT_NS = 1440000000;
	// default reset timeout, value not fixed by the part family
	localparam int RST_DEFAULT_NS = 200000000;
	// 4.348E6 s per farad is 4348 ns per picofarad
	localparam int CAP_NS_PER_PF = 4348;
	localparam int WD_LONG_MULT = 64;
	localparam logic [5:0] WD_LONG_SHIFT = 6'h06;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int CNT_W = 32;
	localparam int CAP_W = 16;
	localparam int LEVEL_W = 5;

	// ----------------------------------------------------------------
	// timing-adjust strap decode
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SGT_PIN_GND = 2'b00,
		SGT_PIN_VCC = 2'b01,
		SGT_PIN_CAP = 2'b10
	} sgt_pin_t;

endpackage

// ==== verilog/sgt_hold.sv ====
// assert-and-hold timer: active while fault stands, then for limit steps
// assumes fault and step are synchronous to sys_clk
`timescale 1ns/10ps
module sgt_hold (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic fault,
	input wire logic step,
	input wire logic [31:0] limit,
	output logic active
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic active_r;
	logic active_nxt;
	wire done = (cnt_r >= limit);

	// a new fault restarts the whole timeout, not just the remainder
	assign cnt_nxt = fault ? 32'h0 : ((step && !done) ? cnt_r + 32'h1 : cnt_r);
	assign active_nxt = fault | !done;
	assign active = active_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
			active_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			active_r <= active_nxt;
		end
	end

endmodule

// ==== verilog/sgt_core.sv ====
// supervisor control: power-good gating, reset and watchdog timing
// assumes comparator flags are synchronous; straps and pins are not
`timescale 1ns/10ps

// Function
// - enable high forces all power-good outputs low
// - after enable release, outputs hold their timeout
// - undriven enable input reads as low
// - watchdog pin grounded disables watchdog entirely
// - watchdog pin high selects default timeout
// - watchdog capacitor timeout: 4.348E6 s per farad
// - reset pin high selects default reset timeout
// - reset capacitor timeout: 4.348E6 s per farad
// - level code applies to all eight inputs
// - power-good low while below, 6.25ms release hold
// - reset low on any rail below threshold or manual reset, held after
// - watchdog cleared by reset or kick edge
// - freeze low holds all outputs but level_sel, overrides manual
module sgt_core #(
	parameter int PG_HOLD_CYC = (sgt_pkg::PG_HOLD_NS + sgt_pkg::CLK_PERIOD_NS - 1)
		/ sgt_pkg::CLK_PERIOD_NS,
	parameter int WD_SHORT_CYC = (sgt_pkg::WD_SHORT_NS + sgt_pkg::CLK_PERIOD_NS - 1)
		/ sgt_pkg::CLK_PERIOD_NS,
	parameter int RST_DEFAULT_CYC = (sgt_pkg::RST_DEFAULT_NS + sgt_pkg::CLK_PERIOD_NS - 1)
		/ sgt_pkg::CLK_PERIOD_NS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] below_thr,
	input wire logic pg_enable_n,
	input wire logic pg_enable_driven,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick,
	input wire logic freeze_n,
	input wire logic [4:0] level_code,
	input wire logic [1:0] watchdog_period_pin,
	input wire logic [1:0] reset_period_pin,
	input wire logic [15:0] wd_cap_pf,
	input wire logic [15:0] rst_cap_pf,
	output logic [4:0] level_sel,
	output logic [7:0] supply_ok_n_oe,
	output logic reset_oe,
	output logic watchdog_fault_n_oe
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int SYNC_W = 14;
	logic [SYNC_W-1:0] pin_s1_r;
	logic [SYNC_W-1:0] pin_s2_r;
	wire [SYNC_W-1:0] pin_raw = {pg_enable_n, pg_enable_driven, manual_reset_n, watchdog_kick,
		freeze_n, level_code, watchdog_period_pin, reset_period_pin};

	// clearing to 0 reads freeze as held and manual reset as pressed for two
	// edges after release; harmless, since every output still shows reset then
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 14'h0000;
			pin_s2_r <= 14'h0000;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	wire en_n_s = pin_s2_r[13];
	wire en_drv_s = pin_s2_r[12];
	wire mr_n_s = pin_s2_r[11];
	wire kick_s = pin_s2_r[10];
	wire freeze_n_s = pin_s2_r[9];
	wire [4:0] level_s = pin_s2_r[8:4];
	wire [1:0] wd_pin_s = pin_s2_r[3:2];
	wire [1:0] rst_pin_s = pin_s2_r[1:0];

	// ----------------------------------------------------------------
	// capacitor time base: one step per picofarad-equivalent
	// ----------------------------------------------------------------
	// an ns accumulator keeps the fractional cycles, so no drift builds up
	logic [12:0] ns_acc_r;
	logic pf_step_r;
	wire [13:0] ns_sum = {1'b0, ns_acc_r} + 14'(sgt_pkg::CLK_PERIOD_NS);
	wire pf_wrap = (ns_sum >= 14'(sgt_pkg::CAP_NS_PER_PF));
	wire [13:0] ns_nxt = pf_wrap ? ns_sum - 14'(sgt_pkg::CAP_NS_PER_PF) : ns_sum;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ns_acc_r <= 13'h0000;
			pf_step_r <= 1'b0;
		end else begin
			ns_acc_r <= ns_nxt[12:0];
			pf_step_r <= pf_wrap;
		end
	end

	// ----------------------------------------------------------------
	// power-good channels
	// ----------------------------------------------------------------
	// a floating enable pin is pulled down, so it reads as released
	wire pg_force = en_drv_s & en_n_s;
	wire [7:0] pg_active;
	// pg hold steps every clock; only the capacitor timers use pf steps

	genvar gi;
	generate
		for (gi = 0; gi < sgt_pkg::NUM_CH; gi++) begin : g_pg
			sgt_hold u_hold (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.fault(below_thr[gi] | pg_force),
				.step(1'b1),
				.limit(32'(PG_HOLD_CYC)),
				.active(pg_active[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// reset timing
	// ----------------------------------------------------------------
	// any code but the capacitor one falls back to the default count
	wire rst_cap_mode = (rst_pin_s == sgt_pkg::SGT_PIN_CAP);
	wire rst_step = rst_cap_mode ? pf_step_r : 1'b1;
	wire [31:0] rst_limit = rst_cap_mode ? {16'h0000, rst_cap_pf} : 32'(RST_DEFAULT_CYC);
	wire rst_fault = (|below_thr) | !mr_n_s;
	wire rst_active;

	sgt_hold u_rst_hold (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fault(rst_fault),
		.step(rst_step),
		.limit(rst_limit),
		.active(rst_active)
	);

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	logic kick_d_r;
	logic wd_armed_r;
	logic wd_armed_nxt;
	logic [31:0] wd_cnt_r;
	logic [31:0] wd_cnt_nxt;
	logic wd_fault_r;
	logic wd_fault_nxt;
	wire kick_edge = kick_s ^ kick_d_r;
	wire wd_off = (wd_pin_s == sgt_pkg::SGT_PIN_GND);
	wire wd_cap_mode = (wd_pin_s == sgt_pkg::SGT_PIN_CAP);
	wire wd_step = wd_cap_mode ? pf_step_r : 1'b1;
	wire [31:0] wd_short = wd_cap_mode ? {16'h0000, wd_cap_pf} : 32'(WD_SHORT_CYC);
	// long period until the first kick after each reset event
	wire [31:0] wd_long = wd_short << sgt_pkg::WD_LONG_SHIFT;
	wire [31:0] wd_limit = wd_armed_r ? wd_short : wd_long;
	wire wd_clear = rst_active | kick_edge | wd_off;
	wire wd_done = (wd_cnt_r >= wd_limit);

	assign wd_armed_nxt = rst_active ? 1'b0 : (wd_armed_r | kick_edge);
	assign wd_cnt_nxt = wd_clear ? 32'h0 : ((wd_step && !wd_done) ? wd_cnt_r + 32'h1 : wd_cnt_r);
	assign wd_fault_nxt = !wd_clear & wd_done;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			kick_d_r <= 1'b0;
			wd_armed_r <= 1'b0;
		end else begin
			kick_d_r <= kick_s;
			wd_armed_r <= wd_armed_nxt;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_r <= 32'h0;
			wd_fault_r <= 1'b0;
		end else begin
			wd_cnt_r <= wd_cnt_nxt;
			wd_fault_r <= wd_fault_nxt;
		end
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	// freeze holds pin states only; timers keep running underneath
	logic [7:0] pg_oe_r;
	logic rst_oe_r;
	logic wd_oe_r;
	logic [4:0] level_r;
	wire [7:0] pg_oe_nxt = freeze_n_s ? pg_active : pg_oe_r;
	wire rst_oe_nxt = freeze_n_s ? rst_active : rst_oe_r;
	wire wd_oe_nxt = freeze_n_s ? wd_fault_r : wd_oe_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pg_oe_r <= 8'hFF;
			rst_oe_r <= 1'b1;
			wd_oe_r <= 1'b0;
		end else begin
			pg_oe_r <= pg_oe_nxt;
			rst_oe_r <= rst_oe_nxt;
			wd_oe_r <= wd_oe_nxt;
		end
	end

	// level code is a static strap, so freeze does not hold it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= 5'h00;
		end else begin
			level_r <= level_s;
		end
	end

	assign level_sel = level_r;
	assign supply_ok_n_oe = pg_oe_r;
	assign reset_oe = rst_oe_r;
	assign watchdog_fault_n_oe = wd_oe_r;

endmodule

// ==== verification/sgt_core_assertions.sv ====
// port assertions for the supervisor core
// assumes bound to sgt_core, inputs settled on sys_clk
`timescale 1ns/10ps
module sgt_core_assertions (
	input logic sys_clk,
	input logic rst_n,
	input logic [7:0] below_thr,
	input logic pg_enable_n,
	input logic pg_enable_driven,
	input logic manual_reset_n,
	input logic freeze_n,
	input logic [4:0] level_code,
	input logic [1:0] watchdog_period_pin,
	input logic [4:0] level_sel,
	input logic [7:0] supply_ok_n_oe,
	input logic reset_oe,
	input logic watchdog_fault_n_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// freeze in the antecedents: a held output may not follow
	sequence s_en_on;
		(pg_enable_n && pg_enable_driven && freeze_n)[*6];
	endsequence
	sequence s_low_then_ok;
		(below_thr[0] && freeze_n)[*6] ##1 !below_thr[0];
	endsequence
	property p_en_force;
		(pg_enable_n && pg_enable_driven && freeze_n)[*4] |=> supply_ok_n_oe == 8'hFF;
	endproperty
	a_en_force: assert property (p_en_force) else $error("pg not forced");
	property p_en_hold;
		s_en_on ##1 !pg_enable_n |-> (supply_ok_n_oe == 8'hFF)[*8];
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("pg released early");
	property p_pg_set;
		freeze_n[*4] ##0 below_thr[7] |-> ##2 supply_ok_n_oe[7];
	endproperty
	a_pg_set: assert property (p_pg_set) else $error("pg not asserted");
	property p_pg_hold;
		s_low_then_ok |-> supply_ok_n_oe[0][*8];
	endproperty
	a_pg_hold: assert property (p_pg_hold) else $error("pg hold short");
	property p_rst_set;
		freeze_n[*4] ##0 (|below_thr) |-> ##2 reset_oe;
	endproperty
	a_rst_set: assert property (p_rst_set) else $error("reset not asserted");
	property p_rst_man;
		(!manual_reset_n && freeze_n)[*5] |=> reset_oe;
	endproperty
	a_rst_man: assert property (p_rst_man) else $error("manual reset ignored");
	property p_freeze;
		(!freeze_n)[*4] |=> $stable(supply_ok_n_oe) && $stable(reset_oe)
			&& $stable(watchdog_fault_n_oe);
	endproperty
	a_freeze: assert property (p_freeze) else $error("output moved in freeze");
	property p_level;
		(rst_n && $stable(level_code))[*4] |-> level_sel == level_code;
	endproperty
	a_level: assert property (p_level) else $error("level not applied");
	property p_wd_off;
		(watchdog_period_pin == 2'h0 && freeze_n)[*4] |=> !watchdog_fault_n_oe;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("watchdog not disabled");
endmodule
bind sgt_core sgt_core_assertions u_chk (.*);

// ==== verification/sgt_rails.sv ====
// rail and kick model facing the supervisor
// assumes one shared sys_clk; flags change only on its edge
`timescale 1ns/10ps
module sgt_rails (
	input logic sys_clk,
	input logic [7:0] rail_low,
	input logic kick_on,
	output logic [7:0] below_thr,
	output logic watchdog_kick
);
	logic [1:0] div_r = 2'h0;
	logic [7:0] low_r = 8'h00;
	logic kick_r = 1'b0;
	assign below_thr = low_r;
	assign watchdog_kick = kick_r;
	always @(posedge sys_clk) begin
		low_r <= rail_low;
		div_r <= div_r + 2'h1;
		if (kick_on && div_r == 2'h3)
			kick_r <= !kick_r;
	end
endmodule

// ==== verification/test_supply_good_enable_and_timeout_select.sv ====
// self-checking bench for the supervisor core
// assumes short timeouts: hold 20, watchdog 10, reset 30 cycles
`timescale 1ns/10ps
module test_supply_good_enable_and_timeout_select;
	logic sys_clk = 0, rst_n = 0, pg_enable_n = 0, pg_enable_driven = 0;
	logic manual_reset_n = 1, freeze_n = 1, kick_on = 1;
	logic [4:0] level_code = 5'h00;
	logic [1:0] watchdog_period_pin = 2'h1, reset_period_pin = 2'h1;
	logic [15:0] wd_cap_pf = 16'h0000, rst_cap_pf = 16'h0000;
	logic [7:0] rail_low = 8'h00;
	wire [7:0] below_thr, supply_ok_n_oe;
	wire [4:0] level_sel;
	wire watchdog_kick, reset_oe, watchdog_fault_n_oe;
	int miscompares = 0, tests_run = 0, cyc = 0;
	logic [4:0] row_in[4] = '{5'h00, 5'h0A, 5'h15, 5'h1F};
	logic [4:0] row_out[4] = '{5'h00, 5'h0A, 5'h15, 5'h1F};
	sgt_core #(.PG_HOLD_CYC(20), .WD_SHORT_CYC(10), .RST_DEFAULT_CYC(30)) dut (.*);
	sgt_rails rails (.*);
	always #20 sys_clk = ~sys_clk;
	task w(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (e !== s) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			miscompares++;
		end
	endtask
	task print_verdict;
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, whole run is under 2500 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			print_verdict;
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		w(20);
		chk("rst", 1, reset_oe);
		w(20);
		chk("rst", 0, reset_oe);
		foreach (row_in[i]) begin
			@(posedge sys_clk) level_code <= row_in[i];
			w(6);
			chk("level_sel", row_out[i], level_sel);
		end
		@(posedge sys_clk) pg_enable_driven <= 1'b1;
		pg_enable_n <= 1'b1;
		w(6);
		chk("pg", 8'hFF, supply_ok_n_oe);
		@(posedge sys_clk) pg_enable_n <= 1'b0;
		w(12);
		chk("pg", 8'hFF, supply_ok_n_oe);
		w(20);
		chk("pg", 8'h00, supply_ok_n_oe);
		@(posedge sys_clk) pg_enable_driven <= 1'b0;
		pg_enable_n <= 1'b1;
		w(8);
		chk("pg", 8'h00, supply_ok_n_oe);
		@(posedge sys_clk) rail_low <= 8'h80;
		w(4);
		chk("pg", 8'h80, supply_ok_n_oe);
		chk("rst", 1, reset_oe);
		@(posedge sys_clk) rail_low <= 8'h00;
		w(15);
		chk("pg", 8'h80, supply_ok_n_oe);
		w(12);
		chk("pg", 8'h00, supply_ok_n_oe);
		@(posedge sys_clk) freeze_n <= 1'b0;
		w(4);
		@(posedge sys_clk) rail_low <= 8'h01;
		w(5);
		chk("pg", 8'h00, supply_ok_n_oe);
		@(posedge sys_clk) freeze_n <= 1'b1;
		w(5);
		chk("pg", 8'h01, supply_ok_n_oe);
		@(posedge sys_clk) rail_low <= 8'h00;
		reset_period_pin <= 2'h2;
		rst_cap_pf <= 16'h0003;
		manual_reset_n <= 1'b0;
		w(8);
		@(posedge sys_clk) manual_reset_n <= 1'b1;
		w(120);
		chk("rst", 1, reset_oe);
		w(240);
		chk("rst", 0, reset_oe);
		chk("wdo", 0, watchdog_fault_n_oe);
		@(posedge sys_clk) kick_on <= 1'b0;
		w(8);
		chk("wdo", 0, watchdog_fault_n_oe);
		w(32);
		chk("wdo", 1, watchdog_fault_n_oe);
		@(posedge sys_clk) kick_on <= 1'b1;
		w(10);
		chk("wdo", 0, watchdog_fault_n_oe);
		@(posedge sys_clk) watchdog_period_pin <= 2'h2;
		wd_cap_pf <= 16'h0003;
		w(10);
		@(posedge sys_clk) kick_on <= 1'b0;
		w(150);
		chk("wdo", 0, watchdog_fault_n_oe);
		w(250);
		chk("wdo", 1, watchdog_fault_n_oe);
		@(posedge sys_clk) kick_on <= 1'b1;
		watchdog_period_pin <= 2'h0;
		w(10);
		@(posedge sys_clk) kick_on <= 1'b0;
		w(700);
		chk("wdo", 0, watchdog_fault_n_oe);
		@(posedge sys_clk) rst_n <= 1'b0;
		w(2);
		chk("pg", 8'hFF, supply_ok_n_oe);
		chk("rst", 1, reset_oe);
		@(posedge sys_clk) rst_n <= 1'b1;
		w(40);
		chk("pg", 8'h00, supply_ok_n_oe);
		chk("rst", 1, reset_oe);
		print_verdict;
	end
endmodule
